// >>> timer8_defs.svh
// Register offsets, field positions, reset values and mode codes of the 8-bit timer.
// Assumes inclusion by bare name from the timer module and the testbench.
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH

// Register offsets on the 8-bit register port
`define T8_ADDR_CTRL_A     8'h00
`define T8_ADDR_CTRL_B     8'h01
`define T8_ADDR_COUNT      8'h02
`define T8_ADDR_CMP_A      8'h03
`define T8_ADDR_CMP_B      8'h04
`define T8_ADDR_FLAGS      8'h05
`define T8_ADDR_PIN_STATUS 8'h06

// Field positions
`define T8_CTRLA_COM_A_HI  7
`define T8_CTRLA_COM_A_LO  6
`define T8_CTRLA_COM_B_HI  5
`define T8_CTRLA_COM_B_LO  4
`define T8_CTRLA_WAVE_HI   1
`define T8_CTRLA_WAVE_LO   0
`define T8_CTRLB_FORCE_A   7
`define T8_CTRLB_FORCE_B   6
`define T8_CTRLB_WAVE_2    3
`define T8_FLAGS_OVF       0
`define T8_FLAGS_CMP_A     1
`define T8_FLAGS_CMP_B     2

// Waveform mode codes
`define T8_WAVE_NORMAL     3'h0
`define T8_WAVE_CLEAR      3'h2
`define T8_WAVE_FPWM_MAX   3'h3
`define T8_WAVE_FPWM_CMP   3'h7

// Counter extremes and reset values
`define T8_BOTTOM          8'h00
`define T8_MAX             8'hff
`define T8_RST_BYTE        8'h00
`define T8_RST_OC          2'h0

`endif

// >>> timer8_pkg.sv
// Types shared by the 8-bit timer waveform logic.
// Assumes timer8_defs.svh is found on the include path.
package timer8_pkg;

    // Compare output action, in field order 0..3
    typedef enum logic [1:0] {
        COM_OFF,
        COM_TOGGLE,
        COM_CLEAR,
        COM_SET
    } com_e;

    typedef struct packed {
        com_e       com_a;
        com_e       com_b;
        logic [2:0] wave;
    } ctrl_s;

    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } flags_s;

endpackage

// >>> timer8_waveform_modes.sv
// 8-bit timer: counter, two compare channels, compare output state and pin override.
// Assumes a same-clock prescaler tick, port data/direction from same-clock port logic,
// and single-cycle strobes on the register port.
//
// Summary of operation
// - Reset clears both compare output state bits to zero.
// - Nonzero output mode puts compare output state on pin; direction stays with port.
// - State reaches the pin only while the port direction bit selects output.
// - Pin override depends only on the output mode field, never the waveform mode.
// - Output mode zero leaves compare output state unchanged at matches.
// - New output mode acts at next match; force strobe acts at once outside PWM.
// - Only waveform mode picks the count sequence; output mode shapes output only.
// - Mode 0 counts up always, never clears, wraps 0xff to 0x00.
// - Normal mode sets overflow flag as counter becomes zero; servicing or writing 1 to its flag bit clears it.
// - Overflow flag clears when its interrupt is serviced.
// - Counter may be written at any time in normal mode.
// - Mode 2 clears the counter when it equals compare value A.
// - Clear-on-match mode raises compare flag A each time top is reached.
// - Compare A unbuffered in mode 2; set below count, counter wraps first.
// - Mode 2 with output mode A of 1 toggles output A every match.
// - Toggle frequency is clock over twice prescale times one plus compare A.
// - Clear-on-match mode sets overflow as counter passes max to 0x00.
// - Modes 3 and 7 are fast PWM; top 0xff or compare value A.
// - Fast PWM non-inverting clears on match, sets at bottom; inverting reversed.
// - Fast PWM counts up to top, then clears on next timer tick.
// - Counter equal to compare value sets that compare flag at the tick.
// - Forced compare updates output only; no flag, no counter clear or reload.
// - Counter write blocks every compare match in the following timer tick.
//
// Implementation choices: the address map and strobed register access.
`include "timer8_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer8_waveform_modes
    import timer8_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic       timer_tick,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic       port_data_a,
    input  wire logic       port_dir_a,
    input  wire logic       port_data_b,
    input  wire logic       port_dir_b,
    input  wire logic       ovf_serviced,
    input  wire logic       cmp_a_serviced,
    input  wire logic       cmp_b_serviced,
    output logic      [7:0] rdata,
    output logic            pin_a_out,
    output logic            pin_a_oe,
    output logic            pin_b_out,
    output logic            pin_b_oe,
    output logic            overflow_flag,
    output logic            compare_flag_a,
    output logic            compare_flag_b
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding shared by counter and output logic

    function automatic logic is_pwm(input logic [2:0] wave);
        is_pwm = (wave == `T8_WAVE_FPWM_MAX) || (wave == `T8_WAVE_FPWM_CMP);
    endfunction

    function automatic logic top_is_cmp(input logic [2:0] wave);
        top_is_cmp = (wave == `T8_WAVE_CLEAR) || (wave == `T8_WAVE_FPWM_CMP);
    endfunction

    // Next compare output state for one channel
    function automatic logic oc_next(
        input logic oc,
        input com_e com,
        input logic pwm,
        input logic toggle_ok,
        input logic match,
        input logic bottom,
        input logic force_now
    );
        logic nxt;
        nxt = oc;
        if (pwm) begin
            // Bottom wins a tie so compare at top gives a steady level
            if (com == COM_CLEAR) begin
                if (bottom) begin
                    nxt = 1'b1;
                end else if (match) begin
                    nxt = 1'b0;
                end
            end else if (com == COM_SET) begin
                if (bottom) begin
                    nxt = 1'b0;
                end else if (match) begin
                    nxt = 1'b1;
                end
            end else if (com == COM_TOGGLE && toggle_ok && match) begin
                nxt = ~oc;
            end
        end else if (match || force_now) begin
            case (com)
                COM_TOGGLE: nxt = ~oc;
                COM_CLEAR:  nxt = 1'b0;
                COM_SET:    nxt = 1'b1;
                default:    nxt = oc;
            endcase
        end
        oc_next = nxt;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    ctrl_s       ctrl_q, ctrl_d;
    flags_s      flags_q, flags_d;
    logic [7:0]  count_q, count_d;
    logic [7:0]  cmp_q [2];
    logic [7:0]  cmp_d [2];
    logic [7:0]  cmp_buf_q [2];
    logic [7:0]  cmp_buf_d [2];
    logic        block_q, block_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [1:0]  oc_q, oc_d;
    logic [1:0]  pin_out_q, pin_out_d;
    logic [1:0]  pin_oe_q, pin_oe_d;

    logic        tick_en;
    logic        pwm;
    logic [7:0]  top;
    logic        at_top;
    logic        count_wr;
    logic        bottom_evt;
    logic        ovf_evt;
    logic [1:0]  match;
    logic [1:0]  force_now;
    logic [1:0]  port_data;
    logic [1:0]  port_dir;
    com_e        com [2];

    assign tick_en    = ce && timer_tick;
    assign pwm        = is_pwm(ctrl_q.wave);
    assign top        = top_is_cmp(ctrl_q.wave) ? cmp_q[0] : `T8_MAX;
    assign at_top     = (count_q == top);
    assign count_wr   = ce && wr && (addr == `T8_ADDR_COUNT);
    assign bottom_evt = tick_en && !count_wr && at_top;
    // Overflow at top in PWM, at max otherwise
    assign ovf_evt    = tick_en && !count_wr && (pwm ? at_top : (count_q == `T8_MAX));
    assign port_data  = {port_data_b, port_data_a};
    assign port_dir   = {port_dir_b, port_dir_a};
    assign com[0]     = ctrl_q.com_a;
    assign com[1]     = ctrl_q.com_b;

    assign force_now[0] = ce && wr && (addr == `T8_ADDR_CTRL_B) && wdata[`T8_CTRLB_FORCE_A] && !pwm;
    assign force_now[1] = ce && wr && (addr == `T8_ADDR_CTRL_B) && wdata[`T8_CTRLB_FORCE_B] && !pwm;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter, control, compare values, flags and register reads

    always_comb begin
        ctrl_d    = ctrl_q;
        flags_d   = flags_q;
        count_d   = count_q;
        cmp_d     = cmp_q;
        cmp_buf_d = cmp_buf_q;
        block_d   = block_q;
        rdata_d   = 8'h00;

        // Only the waveform field shapes the count sequence
        if (tick_en) begin
            block_d = 1'b0;
            if (at_top) begin
                count_d = `T8_BOTTOM;
            end else begin
                count_d = 8'(count_q + 8'h01);
            end
        end
        // Compare buffers load at top-to-bottom in PWM; direct otherwise
        if (pwm && bottom_evt) begin
            cmp_d = cmp_buf_q;
        end

        if (ce && wr) begin
            if (addr == `T8_ADDR_CTRL_A) begin
                ctrl_d.com_a     = com_e'(wdata[`T8_CTRLA_COM_A_HI:`T8_CTRLA_COM_A_LO]);
                ctrl_d.com_b     = com_e'(wdata[`T8_CTRLA_COM_B_HI:`T8_CTRLA_COM_B_LO]);
                ctrl_d.wave[1:0] = wdata[`T8_CTRLA_WAVE_HI:`T8_CTRLA_WAVE_LO];
            end else if (addr == `T8_ADDR_CTRL_B) begin
                ctrl_d.wave[2]   = wdata[`T8_CTRLB_WAVE_2];
            end else if (addr == `T8_ADDR_COUNT) begin
                count_d = wdata;
                block_d = 1'b1;
            end else if (addr == `T8_ADDR_CMP_A) begin
                cmp_buf_d[0] = wdata;
                if (!pwm) begin
                    cmp_d[0] = wdata;
                end
            end else if (addr == `T8_ADDR_CMP_B) begin
                cmp_buf_d[1] = wdata;
                if (!pwm) begin
                    cmp_d[1] = wdata;
                end
            end
        end

        // Set beats clear in the same cycle
        flags_d.ovf   = ovf_evt || (flags_q.ovf && !(ce && ovf_serviced) &&
                        !(ce && wr && addr == `T8_ADDR_FLAGS && wdata[`T8_FLAGS_OVF]));
        flags_d.cmp_a = match[0] || (flags_q.cmp_a && !(ce && cmp_a_serviced) &&
                        !(ce && wr && addr == `T8_ADDR_FLAGS && wdata[`T8_FLAGS_CMP_A]));
        flags_d.cmp_b = match[1] || (flags_q.cmp_b && !(ce && cmp_b_serviced) &&
                        !(ce && wr && addr == `T8_ADDR_FLAGS && wdata[`T8_FLAGS_CMP_B]));

        if (ce && rd) begin
            if (addr == `T8_ADDR_CTRL_A) begin
                rdata_d = {ctrl_q.com_a, ctrl_q.com_b, 2'h0, ctrl_q.wave[1:0]};
            end else if (addr == `T8_ADDR_CTRL_B) begin
                rdata_d = {4'h0, ctrl_q.wave[2], 3'h0};
            end else if (addr == `T8_ADDR_COUNT) begin
                rdata_d = count_q;
            end else if (addr == `T8_ADDR_CMP_A) begin
                rdata_d = cmp_buf_q[0];
            end else if (addr == `T8_ADDR_CMP_B) begin
                rdata_d = cmp_buf_q[1];
            end else if (addr == `T8_ADDR_FLAGS) begin
                rdata_d = {5'h00, flags_q.cmp_b, flags_q.cmp_a, flags_q.ovf};
            end else if (addr == `T8_ADDR_PIN_STATUS) begin
                rdata_d = {2'h0, oc_q, pin_oe_q[1], pin_out_q[1], pin_oe_q[0], pin_out_q[0]};
            end else begin
                rdata_d = 8'h00;
            end
        end
        if (!ce) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q       <= '0;
            flags_q      <= '0;
            count_q      <= `T8_RST_BYTE;
            cmp_q[0]     <= `T8_RST_BYTE;
            cmp_q[1]     <= `T8_RST_BYTE;
            cmp_buf_q[0] <= `T8_RST_BYTE;
            cmp_buf_q[1] <= `T8_RST_BYTE;
            block_q      <= 1'b0;
            rdata_q      <= `T8_RST_BYTE;
        end else if (ce) begin
            ctrl_q    <= ctrl_d;
            flags_q   <= flags_d;
            count_q   <= count_d;
            cmp_q     <= cmp_d;
            cmp_buf_q <= cmp_buf_d;
            block_q   <= block_d;
            rdata_q   <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare channels and pin override

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            // A counter write holds matches off for one tick
            assign match[ch] = tick_en && !count_wr && !block_q && (count_q == cmp_q[ch]);

            always_comb begin
                // Toggle in PWM only for channel A with compare-A top
                oc_d[ch] = oc_next(oc_q[ch], com[ch], pwm,
                                   (ch == 0) && ctrl_q.wave[2],
                                   match[ch], bottom_evt, force_now[ch]);
                // Mode-independent override; direction from the port
                pin_out_d[ch] = (com[ch] != COM_OFF) ? oc_q[ch] : port_data[ch];
                pin_oe_d[ch]  = port_dir[ch];
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    oc_q[ch]      <= 1'b0;
                    pin_out_q[ch] <= 1'b0;
                    pin_oe_q[ch]  <= 1'b0;
                end else if (ce) begin
                    oc_q[ch]      <= oc_d[ch];
                    pin_out_q[ch] <= pin_out_d[ch];
                    pin_oe_q[ch]  <= pin_oe_d[ch];
                end
            end
        end
    endgenerate

    assign rdata          = rdata_q;
    assign pin_a_out      = pin_out_q[0];
    assign pin_a_oe       = pin_oe_q[0];
    assign pin_b_out      = pin_out_q[1];
    assign pin_b_oe       = pin_oe_q[1];
    assign overflow_flag  = flags_q.ovf;
    assign compare_flag_a = flags_q.cmp_a;
    assign compare_flag_b = flags_q.cmp_b;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_reset_oc;
        @(posedge clk) reset |=> (oc_q == `T8_RST_OC);
    endproperty
    a_reset_oc: assert property (p_reset_oc) else $error("compare state not zero in reset");

    property p_override_a;
        @(posedge clk) disable iff (reset)
        (ce && ctrl_q.com_a != COM_OFF) |=> (pin_a_out == $past(oc_q[0]));
    endproperty
    a_override_a: assert property (p_override_a) else $error("pin A not driven by compare state");

    property p_dir_b;
        @(posedge clk) disable iff (reset)
        ce |=> (pin_b_oe == $past(port_dir_b));
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("pin B enable not following direction");

    property p_com_off_hold;
        @(posedge clk) disable iff (reset)
        (tick_en && ctrl_q.com_b == COM_OFF) |=> $stable(oc_q[1]);
    endproperty
    a_com_off_hold: assert property (p_com_off_hold) else $error("output B moved with mode off");

    property p_normal_inc;
        @(posedge clk) disable iff (reset)
        (tick_en && !count_wr && ctrl_q.wave == `T8_WAVE_NORMAL) |=> (count_q == 8'($past(count_q) + 8'h01));
    endproperty
    a_normal_inc: assert property (p_normal_inc) else $error("normal mode did not increment");

    property p_normal_ovf;
        @(posedge clk) disable iff (reset)
        (tick_en && !count_wr && ctrl_q.wave == `T8_WAVE_NORMAL && count_q == `T8_MAX)
            |=> (overflow_flag && count_q == `T8_BOTTOM);
    endproperty
    a_normal_ovf: assert property (p_normal_ovf) else $error("overflow not set at wrap");

    property p_ctc_clear;
        @(posedge clk) disable iff (reset)
        (tick_en && !count_wr && ctrl_q.wave == `T8_WAVE_CLEAR && count_q == cmp_q[0])
            |=> (count_q == `T8_BOTTOM);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match did not clear");

    property p_ctc_toggle;
        @(posedge clk) disable iff (reset)
        (ctrl_q.wave == `T8_WAVE_CLEAR && ctrl_q.com_a == COM_TOGGLE && match[0])
            |=> (oc_q[0] != $past(oc_q[0]));
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle) else $error("output A did not toggle");

    // Helper: counter written and no tick since, however long the timer stays stopped
    logic        wr_seen_q, wr_seen_d;

    always_comb begin
        wr_seen_d = count_wr || (wr_seen_q && !tick_en);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_seen_q <= 1'b0;
        end else if (ce) begin
            wr_seen_q <= wr_seen_d;
        end
    end

    property p_block;
        @(posedge clk) disable iff (reset)
        (wr_seen_q && tick_en && !compare_flag_b) |=> !compare_flag_b;
    endproperty
    a_block: assert property (p_block) else $error("match not blocked after counter write");

    property p_force_no_flag;
        @(posedge clk) disable iff (reset)
        (force_now[0] && !tick_en && !compare_flag_a) |=> !compare_flag_a;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) else $error("force set the compare flag");

    c_ctc_toggle: cover property (@(posedge clk) disable iff (reset)
        ctrl_q.wave == `T8_WAVE_CLEAR && ctrl_q.com_a == COM_TOGGLE && match[0]);
    c_pwm_bottom: cover property (@(posedge clk) disable iff (reset) pwm && bottom_evt);
    c_overflow:   cover property (@(posedge clk) disable iff (reset) ovf_evt);
    c_force:      cover property (@(posedge clk) disable iff (reset) force_now[1]);

endmodule

`default_nettype wire

// >>> timer8_port_model.sv
// Port pin logic and external load for the timer's two compare pins.
// Assumes the bench loads port data and direction with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none

module timer8_port_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       load,
    input  wire logic [1:0] data_in,
    input  wire logic [1:0] dir_in,
    input  wire logic       pin_a_out,
    input  wire logic       pin_a_oe,
    input  wire logic       pin_b_out,
    input  wire logic       pin_b_oe,
    output logic            port_data_a,
    output logic            port_dir_a,
    output logic            port_data_b,
    output logic            port_dir_b,
    output logic            pin_a_level,
    output logic            pin_b_level
);
    logic [3:0] port_q;
    logic [3:0] port_d;

    always_comb begin
        port_d = load ? {dir_in, data_in} : port_q;
    end

    // Pins start as inputs until software picks output
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_q <= 4'h0;
        end else begin
            port_q <= port_d;
        end
    end

    assign {port_dir_b, port_dir_a, port_data_b, port_data_a} = port_q;
    // Pull-up on the load, so an undriven pin never shows the last value
    assign pin_a_level = pin_a_oe ? pin_a_out : 1'b1;
    assign pin_b_level = pin_b_oe ? pin_b_out : 1'b1;
endmodule

`default_nettype wire

// >>> timer8_waveform_modes_tb.sv
// Self-checking bench for the 8-bit timer waveform logic, random rounds over modes 0, 2, 3 and 7.
// Assumes timer8_defs.svh on the include path and the port model beside it.
`include "timer8_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer8_waveform_modes_tb;
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    logic            ce = 1'b1;
    logic            timer_tick = 1'b0;
    logic      [7:0] addr = 8'h00;
    logic      [7:0] wdata = 8'h00;
    logic            wr = 1'b0;
    logic            rd = 1'b0;
    logic      [2:0] svc = 3'h0;
    logic            load = 1'b0;
    logic      [1:0] pdata = 2'h0;
    logic      [1:0] pdir = 2'h0;
    logic            port_data_a, port_dir_a, port_data_b, port_dir_b;
    logic      [7:0] rdata;
    logic            pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pin_a_level, pin_b_level;
    logic            overflow_flag, compare_flag_a, compare_flag_b;
    int              errors = 0;
    int              checks = 0;
    int              cycles = 0;
    logic     [31:0] seed = 32'h0b5d;
    logic      [7:0] m_cnt;
    logic [1:0][7:0] m_cmp;
    logic [1:0][1:0] m_com;
    logic      [1:0] m_oc;
    logic      [2:0] m_flags;
    logic      [2:0] m_mode;
    logic            m_block;

    always #12.5 clk = ~clk;

    timer8_waveform_modes timer8_waveform_modes_i (.clk(clk), .reset(reset), .ce(ce), .timer_tick(timer_tick),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .port_data_a(port_data_a), .port_dir_a(port_dir_a),
        .port_data_b(port_data_b), .port_dir_b(port_dir_b), .ovf_serviced(svc[0]), .cmp_a_serviced(svc[1]),
        .cmp_b_serviced(svc[2]), .rdata(rdata), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .overflow_flag(overflow_flag),
        .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b));

    timer8_port_model timer8_port_model_i (.clk(clk), .reset(reset), .load(load), .data_in(pdata),
        .dir_in(pdir), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .port_data_a(port_data_a), .port_dir_a(port_dir_a), .port_data_b(port_data_b),
        .port_dir_b(port_dir_b), .pin_a_level(pin_a_level), .pin_b_level(pin_b_level));

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Bottom beats match in fast PWM, so a compare at top gives a steady level
    function automatic logic oc_next(logic oc, logic [1:0] com, logic pwm, logic tog, logic m, logic b);
        if (pwm && com[1] && b) return ~com[0];
        if (!m || com == 2'd0) return oc;
        if (com == 2'd1) return (pwm && !tog) ? oc : ~oc;
        return com[0];
    endfunction

    function automatic logic [7:0] pin_status();
        logic oa;
        logic ob;
        oa = (m_com[0] != 2'd0) ? m_oc[0] : pdata[0];
        ob = (m_com[1] != 2'd0) ? m_oc[1] : pdata[1];
        return {2'b00, m_oc[1], m_oc[0], pdir[1], ob, pdir[0], oa};
    endfunction

    task automatic ref_tick();
        logic       pwm;
        logic [7:0] top;
        logic [1:0] hit;
        logic       b;
        pwm = (m_mode == 3'd3) || (m_mode == 3'd7);
        top = (m_mode == 3'd2 || m_mode == 3'd7) ? m_cmp[0] : 8'hff;
        b = (m_cnt == top);
        hit = m_block ? 2'b00 : {m_cnt == m_cmp[1], m_cnt == m_cmp[0]};
        if (pwm ? b : m_cnt == 8'hff) m_flags[0] = 1'b1;
        m_flags[2:1] = m_flags[2:1] | hit;
        m_oc[0] = oc_next(m_oc[0], m_com[0], pwm, m_mode == 3'd7, hit[0], b);
        m_oc[1] = oc_next(m_oc[1], m_com[1], pwm, 1'b0, hit[1], b);
        m_cnt = b ? 8'h00 : m_cnt + 8'h01;
        m_block = 1'b0;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, exp, rdata);
    endtask

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        {m_cnt, m_oc, m_flags, m_mode, m_block, m_com, m_cmp, pdata, pdir} = '0;
        #1;
        check("outputs", 8'h00, {1'b0, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, overflow_flag,
            compare_flag_a, compare_flag_b});
        bus_rd(`T8_ADDR_PIN_STATUS, 8'h00, "pin status");
    endtask

    task automatic check_pins();
        logic [7:0] ps;
        ps = pin_status();
        check("pin_a_out", {7'h0, ps[0]}, {7'h0, pin_a_out});
        check("pin_a_oe", {7'h0, ps[1]}, {7'h0, pin_a_oe});
        check("pin_b_out", {7'h0, ps[2]}, {7'h0, pin_b_out});
        check("pin_b_oe", {7'h0, ps[3]}, {7'h0, pin_b_oe});
        check("pin_a_level", {7'h0, ps[1] ? ps[0] : 1'b1}, {7'h0, pin_a_level});
        check("pin_b_level", {7'h0, ps[3] ? ps[2] : 1'b1}, {7'h0, pin_b_level});
        bus_rd(`T8_ADDR_PIN_STATUS, ps, "pin status");
    endtask

    ////////////////////////////////////////////////////////////////
    // Counter written with the tick stopped, so the first tick is the blocked one
    task automatic round(input int i);
        logic [31:0] r;
        logic  [7:0] st;
        int          n;
        r = rnd();
        m_mode = {i[1] & i[0], i[1] | i[0], i[1]};
        m_com[0] = r[7:6];
        m_com[1] = r[5:4];
        m_cmp[0] = 8'h01 + 8'(rnd() % 48);
        m_cmp[1] = 8'(rnd() % 64);
        st = r[0] ? (m_cmp[0] ^ 8'h80) : (m_cmp[0] >> 1);
        // Corner: count written equal to compare B, first match must be lost
        if (i % 5 == 4) begin
            st = m_cmp[1];
        end
        bus_wr(`T8_ADDR_CTRL_A, 8'h00);
        bus_wr(`T8_ADDR_CTRL_B, 8'h00);
        bus_wr(`T8_ADDR_CMP_A, m_cmp[0]);
        bus_wr(`T8_ADDR_CMP_B, m_cmp[1]);
        bus_wr(`T8_ADDR_COUNT, st);
        m_cnt = st;
        m_block = 1'b1;
        pdata = r[3:2];
        pdir = r[9:8];
        @(posedge clk);
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        bus_wr(`T8_ADDR_CTRL_B, {4'h0, m_mode[2], 3'h0});
        bus_wr(`T8_ADDR_CTRL_A, {m_com[0], m_com[1], 2'b00, m_mode[1:0]});
        bus_rd(`T8_ADDR_CTRL_B, {4'h0, m_mode[2], 3'h0}, "ctrl_b");
        bus_wr(`T8_ADDR_FLAGS, 8'h07);
        m_flags = 3'h0;
        if (r[1]) begin
            // Force is tried in PWM too, where it must do nothing
            bus_wr(`T8_ADDR_CTRL_B, {4'hc, m_mode[2], 3'h0});
            if (m_mode[1:0] != 2'd3) begin
                m_oc[0] = oc_next(m_oc[0], m_com[0], 1'b0, 1'b0, 1'b1, 1'b0);
                m_oc[1] = oc_next(m_oc[1], m_com[1], 1'b0, 1'b0, 1'b1, 1'b0);
            end
            bus_rd(`T8_ADDR_COUNT, st, "count after force");
            check("flags after force", 8'h00, {5'h0, compare_flag_b, compare_flag_a, overflow_flag});
            bus_rd(`T8_ADDR_PIN_STATUS, pin_status(), "state after force");
        end
        n = 40 + int'(rnd() % 300);
        repeat (n) begin
            @(posedge clk);
            if (ce && timer_tick) ref_tick();
            r = rnd();
            ce <= r[3:1] != 3'h0;
            timer_tick <= r[0];
        end
        @(posedge clk);
        if (ce && timer_tick) ref_tick();
        ce <= 1'b1;
        timer_tick <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("flag outputs", {5'h0, m_flags}, {5'h0, compare_flag_b, compare_flag_a, overflow_flag});
        bus_rd(`T8_ADDR_COUNT, m_cnt, "count");
        bus_rd(`T8_ADDR_FLAGS, {5'h0, m_flags}, "flags register");
        check_pins();
        @(posedge clk);
        svc <= 3'h7;
        @(posedge clk);
        svc <= 3'h0;
        m_flags = 3'h0;
        #1;
        check("flags serviced", 8'h00, {5'h0, compare_flag_b, compare_flag_a, overflow_flag});
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        do_reset();
        bus_wr(8'h07, 8'h5a);
        bus_rd(8'h07, 8'h00, "unmapped read");
        for (int i = 0; i < 40; i++) begin
            round(i);
        end
        do_reset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
